// ---- hdl/sdc_cmd_seq.sv ----
`timescale 1ns/10ps
module sdc_cmd_seq
  import sdc_pkg::*;
(
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic resetn,
  // controller side
  sdc_seq_if.seq    seq
);
  sdc_seq_state_t state;
  sdc_seq_state_t next_state;
  logic           refPend;
  logic           modePend;
  logic           isMode;
  logic           next_isMode;
  logic [1:0]     bank;
  logic [1:0]     next_bank;
  logic [2:0]     gapCnt;
  logic [2:0]     next_gapCnt;
  logic [2:0]     gapLen;
  logic           takeWork;

  // stagger code to memory clocks between bank refreshes
  always_comb begin
    case (seq.stagger)
      2'h0:    gapLen = 3'h0;
      2'h1:    gapLen = 3'h1;
      2'h2:    gapLen = 3'h2;
      default: gapLen = 3'h4;
    endcase
  end

  // next state, evaluated on memory clock enables only
  always_comb begin
    next_state  = state;
    next_isMode = isMode;
    next_bank   = bank;
    next_gapCnt = gapCnt;
    takeWork    = 1'b0;
    case (state)
      SEQ_IDLE: begin
        if (modePend || refPend) begin
          takeWork    = 1'b1;
          next_isMode = modePend; // mode set goes ahead of a waiting refresh
          next_bank   = 2'h0;
          next_state  = seq.twoCycle ? SEQ_SETUP : SEQ_CMD;
        end
      end
      SEQ_SETUP: next_state = SEQ_CMD;
      SEQ_CMD: begin
        if (isMode || bank == 2'h3) begin
          next_state = SEQ_IDLE;
        end else if (gapLen == 3'h0) begin
          next_bank = bank + 2'h1;
        end else begin
          next_gapCnt = gapLen - 3'h1;
          next_state  = SEQ_GAP;
        end
      end
      SEQ_GAP: begin
        if (gapCnt == 3'h0) begin
          next_bank  = bank + 2'h1;
          next_state = SEQ_CMD;
        end else begin
          next_gapCnt = gapCnt - 3'h1;
        end
      end
      default: next_state = SEQ_IDLE;
    endcase
  end

  // pending requests; a new request beats the take in the same cycle
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      refPend  <= 1'b0;
      modePend <= 1'b0;
    end else begin
      if (seq.refreshReq) refPend <= 1'b1;
      else if (seq.memClkEn && takeWork && !modePend) refPend <= 1'b0;
      if (seq.modeSetReq) modePend <= 1'b1;
      else if (seq.memClkEn && takeWork) modePend <= 1'b0;
    end
  end

  // state and registered pin drive
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state       <= SEQ_IDLE;
      isMode      <= 1'b0;
      bank        <= 2'h0;
      gapCnt      <= 3'h0;
      seq.memCsN  <= 1'b1;
      seq.memCmd  <= CMD_NOP;
      seq.memBank <= 2'h0;
      seq.memAddr <= '0;
      seq.busy    <= 1'b0;
    end else if (seq.memClkEn) begin
      state       <= next_state;
      isMode      <= next_isMode;
      bank        <= next_bank;
      gapCnt      <= next_gapCnt;
      seq.busy    <= (next_state != SEQ_IDLE);
      seq.memCsN  <= (next_state != SEQ_CMD); // address leads select by a clock in setup
      seq.memCmd  <= (next_state == SEQ_CMD) ? (next_isMode ? CMD_MODE_SET : CMD_REFRESH) : CMD_NOP;
      seq.memBank <= next_bank;
      // mode word carries the programmed latency
      seq.memAddr <= next_isMode ? (MEM_ADDR_WIDTH'(seq.casLat) << MODE_CAS_LSB) : '0;
    end
  end

  setup_lead_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (seq.memClkEn && state == SEQ_SETUP) |=> (!seq.memCsN && seq.memCmd != CMD_NOP))
    else $error("select did not follow the address setup clock");
  mode_latency_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (seq.memCmd == CMD_MODE_SET) |-> (seq.memAddr[MODE_CAS_LSB +: CAS_LAT_WIDTH] == seq.casLat))
    else $error("mode set word lacks the latency setting");
  stagger_zero_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (seq.memClkEn && state == SEQ_CMD && !isMode && bank != 2'h3 && seq.stagger == 2'h0)
      |=> (!seq.memCsN && seq.memBank == $past(bank) + 2'h1))
    else $error("zero stagger left a gap between banks");
  cover_refresh_c: cover property (@(posedge ref_clk) disable iff (!resetn)
    seq.memCmd == CMD_REFRESH && seq.memBank == 2'h3);
  cover_mode_c: cover property (@(posedge ref_clk) disable iff (!resetn)
    seq.memCmd == CMD_MODE_SET && seq.twoCycle);
endmodule : sdc_cmd_seq

// ---- hdl/sdc_ctrl_top.sv ----
// Added by the designer: the address-and-strobe port.
`timescale 1ns/10ps
// Overview of operation
// - refresh commands to four banks spaced by 0, 1, 2 or 4 memory clocks
// - two cycle setup drives the address one memory clock before select
// - setting the test refresh bit raises one refresh request
// - round robin mode rotates cpu, graphics and low display at equal priority
// - fixed mode puts cpu above graphics and low display
// - urgent display requests always win in either mode
// - remap enable maps the window above config base onto A0000 to BFFFF
// - programming bit issues a mode set carrying the latency setting
// - mode programming starts only on a written zero to one change
// - feedback clock pin driven while its mask bit is zero
// - each of four memory clock pins driven while its mask bit is zero
// - clock output register resets to 801h, bits 31 to 14 read zero
module sdc_ctrl_top
  import sdc_pkg::*;
(
  // clock and reset
  input  wire logic                      ref_clk,
  input  wire logic                      resetn,
  // register port
  input  wire logic [15:0]               busAddr,
  input  wire logic [31:0]               busWrData,
  input  wire logic                      busWr,
  input  wire logic                      busRd,
  output var  logic [31:0]               busRdData,
  // refresh interval tick from the refresh timer
  input  wire logic                      refreshTick,
  // internal bus requesters and grant
  input  wire logic                      cpuReq,
  input  wire logic                      gfxReq,
  input  wire logic                      dispLoReq,
  input  wire logic                      dispHiReq,
  output var  logic [3:0]                grant,
  // address remap
  input  wire logic [31:0]               configBase,
  input  wire logic [31:0]               reqAddr,
  output var  logic                      remapHit,
  output var  logic [31:0]               remapAddr,
  // memory command pins
  output var  logic                      memCsN,
  output var  logic [2:0]                memCmd,
  output var  logic [1:0]                memBank,
  output var  logic [MEM_ADDR_WIDTH-1:0] memAddr,
  // memory clock pin enables
  output var  logic [3:0]                memClkOe,
  output var  logic                      fbClkOe
);
  logic [31:0]              memCtlLow;
  logic [CLK_CTL_WIDTH-1:0] clkOutCtl;
  logic [CAS_LAT_WIDTH-1:0] casLat;
  logic                     wrLow;
  logic                     modeStart;
  logic                     testPrev;
  logic                     testRefPulse;
  logic [2:0]               divCnt;
  logic                     memClkEn;
  logic [1:0]               lastLo;
  logic [3:0]               next_grant;
  logic [31:0]              winOffset;
  sdc_seq_if                seqBus ();

  assign wrLow = busWr && (busAddr == MEM_CTL_LOW_ADDR);

  // register writes; the reserved low bit is never stored
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      memCtlLow <= MEM_CTL_LOW_RESET;
      clkOutCtl <= CLK_OUT_CTL_RESET;
      casLat    <= CAS_LAT_RESET;
    end else if (busWr) begin
      case (busAddr)
        MEM_CTL_LOW_ADDR: begin
          memCtlLow               <= busWrData;
          memCtlLow[RSVD_LOW_BIT] <= 1'b0;
        end
        CLK_OUT_CTL_ADDR: clkOutCtl <= busWrData[CLK_CTL_WIDTH-1:0];
        SYNC_TIMING_ADDR: casLat    <= busWrData[CAS_LAT_WIDTH-1:0];
        default: ;
      endcase
    end
  end

  // read data stands for the one cycle after the strobe only
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      busRdData <= 32'h0000_0000;
    end else if (busRd) begin
      case (busAddr)
        MEM_CTL_LOW_ADDR: busRdData <= memCtlLow;
        CLK_OUT_CTL_ADDR: busRdData <= {18'h0_0000, clkOutCtl}; // upper bits read zero
        SYNC_TIMING_ADDR: busRdData <= {29'h0000_0000, casLat};
        default:          busRdData <= 32'h0000_0000;
      endcase
    end else begin
      busRdData <= 32'h0000_0000;
    end
  end

  // mode set start: written one against stored zero, one cycle wide
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      modeStart <= 1'b0;
    end else begin
      modeStart <= wrLow && busWrData[MRS_PROG_BIT] && !memCtlLow[MRS_PROG_BIT];
    end
  end

  // test refresh fires once per rise of the stored bit; holding it high does not repeat
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      testPrev     <= 1'b0;
      testRefPulse <= 1'b0;
    end else begin
      testPrev     <= memCtlLow[TEST_REFRESH_BIT];
      testRefPulse <= memCtlLow[TEST_REFRESH_BIT] && !testPrev;
    end
  end

  // memory clock rate as a one cycle enable
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      divCnt   <= 3'h0;
      memClkEn <= 1'b0;
    end else begin
      memClkEn <= (divCnt == MEM_CLK_DIV - 3'h1);
      divCnt   <= (divCnt == MEM_CLK_DIV - 3'h1) ? 3'h0 : divCnt + 3'h1;
    end
  end

  // feed the command sequencer
  assign seqBus.memClkEn   = memClkEn;
  assign seqBus.refreshReq = refreshTick || testRefPulse;
  assign seqBus.modeSetReq = modeStart;
  assign seqBus.stagger    = memCtlLow[STAGGER_LSB +: 2]; // single bank setups rely on software writing zero
  assign seqBus.twoCycle   = memCtlLow[TWO_CYCLE_BIT];
  assign seqBus.casLat     = casLat;

  sdc_cmd_seq u_seq (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .seq     (seqBus)
  );

  assign memCsN  = seqBus.memCsN;
  assign memCmd  = seqBus.memCmd;
  assign memBank = seqBus.memBank;
  assign memAddr = seqBus.memAddr;

  // arbitration: urgent display first, then mode dependent order
  always_comb begin
    next_grant = 4'h0;
    if (dispHiReq) begin
      next_grant[GNT_DISP_HI] = 1'b1;
    end else if (!memCtlLow[ROUND_ROBIN_BIT]) begin
      if (cpuReq) next_grant[GNT_CPU] = 1'b1;
      else if (gfxReq) next_grant[GNT_GFX] = 1'b1;
      else if (dispLoReq) next_grant[GNT_DISP_LO] = 1'b1;
    end else begin
      // rotate from the requester after the last one served
      case (lastLo)
        2'h0: begin
          if (gfxReq) next_grant[GNT_GFX] = 1'b1;
          else if (dispLoReq) next_grant[GNT_DISP_LO] = 1'b1;
          else if (cpuReq) next_grant[GNT_CPU] = 1'b1;
        end
        2'h1: begin
          if (dispLoReq) next_grant[GNT_DISP_LO] = 1'b1;
          else if (cpuReq) next_grant[GNT_CPU] = 1'b1;
          else if (gfxReq) next_grant[GNT_GFX] = 1'b1;
        end
        default: begin
          if (cpuReq) next_grant[GNT_CPU] = 1'b1;
          else if (gfxReq) next_grant[GNT_GFX] = 1'b1;
          else if (dispLoReq) next_grant[GNT_DISP_LO] = 1'b1;
        end
      endcase
    end
  end

  // grant register and rotation pointer
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      grant  <= 4'h0;
      lastLo <= 2'h2;
    end else begin
      grant <= next_grant;
      if (next_grant[GNT_CPU]) lastLo <= 2'h0;
      else if (next_grant[GNT_GFX]) lastLo <= 2'h1;
      else if (next_grant[GNT_DISP_LO]) lastLo <= 2'h2;
    end
  end

  // remap window; unsigned difference also rejects addresses below the window
  assign winOffset = reqAddr - (configBase + REMAP_WIN_OFFSET);

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      remapHit  <= 1'b0;
      remapAddr <= 32'h0000_0000;
    end else begin
      remapHit  <= memCtlLow[REMAP_EN_BIT] && (winOffset < REMAP_WIN_SIZE);
      remapAddr <= REMAP_PHYS_BASE + winOffset;
    end
  end

  // clock pin enables are the inverse of the mask bits
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      memClkOe <= 4'h0;
      fbClkOe  <= 1'b0;
    end else begin
      memClkOe <= ~clkOutCtl[CLK_MASK_LSB +: 4];
      fbClkOe  <= ~clkOutCtl[FB_CLK_MASK_BIT];
    end
  end

  mode_pulse_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    modeStart |=> !modeStart)
    else $error("mode start lasted more than one cycle");
  // the stored bit itself must have gone from zero to one at the write that raised the start
  mode_edge_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    modeStart |-> (memCtlLow[MRS_PROG_BIT] && !$past(memCtlLow[MRS_PROG_BIT])))
    else $error("mode start without a written rising edge");
  urgent_disp_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    dispHiReq |=> (grant == 4'h8))
    else $error("urgent display request not granted");
  fixed_cpu_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (!memCtlLow[ROUND_ROBIN_BIT] && cpuReq && !dispHiReq && !wrLow) |=> grant[GNT_CPU])
    else $error("fixed order did not favour the processor");
  rr_rotate_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (memCtlLow[ROUND_ROBIN_BIT] && !wrLow && grant[GNT_CPU] && cpuReq && gfxReq && !dispHiReq)
      |=> grant[GNT_GFX])
    else $error("round robin served the processor twice");
  remap_off_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    !memCtlLow[REMAP_EN_BIT] |=> !remapHit)
    else $error("remap hit while remap disabled");
  // skip the edge right after release: the enables still hold their reset value there
  clk_pins_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    $past(resetn) |-> (memClkOe == ~$past(clkOutCtl[CLK_MASK_LSB +: 4])))
    else $error("clock pin enable does not follow its mask");
  fb_pin_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    $past(resetn) |-> (fbClkOe == !$past(clkOutCtl[FB_CLK_MASK_BIT])))
    else $error("feedback clock enable does not follow its mask");
  rsvd_read_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (busRd && busAddr == CLK_OUT_CTL_ADDR) |=> (busRdData[31:14] == 18'h0_0000))
    else $error("reserved clock control bits read nonzero");
  test_ref_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    $rose(memCtlLow[TEST_REFRESH_BIT]) |=> testRefPulse ##1 !testRefPulse)
    else $error("test refresh bit gave no single request");
  cover_rr_c: cover property (@(posedge ref_clk) disable iff (!resetn)
    memCtlLow[ROUND_ROBIN_BIT] && grant[GNT_GFX] ##1 grant[GNT_DISP_LO]);
  cover_remap_c: cover property (@(posedge ref_clk) disable iff (!resetn) remapHit);
endmodule : sdc_ctrl_top

// ---- hdl/sdc_pkg.sv ----
package sdc_pkg;
  // register byte addresses on the plain register port
  localparam logic [15:0] MEM_CTL_LOW_ADDR   = 16'h8400;
  localparam logic [15:0] CLK_OUT_CTL_ADDR   = 16'h8404;
  localparam logic [15:0] SYNC_TIMING_ADDR   = 16'h840C;
  // reset values
  localparam logic [31:0] MEM_CTL_LOW_RESET  = 32'h248C0040;
  localparam logic [13:0] CLK_OUT_CTL_RESET  = 14'h0801;
  localparam logic [2:0]  CAS_LAT_RESET      = 3'h2;
  // memory_control_low field positions
  localparam int          MRS_PROG_BIT       = 0;
  localparam int          RSVD_LOW_BIT       = 1;
  localparam int          REMAP_EN_BIT       = 2;
  localparam int          ROUND_ROBIN_BIT    = 3;
  localparam int          TEST_REFRESH_BIT   = 4;
  localparam int          TWO_CYCLE_BIT      = 5;
  localparam int          STAGGER_LSB        = 6;
  // clock_output_control field positions
  localparam int          CLK_MASK_LSB       = 6;
  localparam int          FB_CLK_MASK_BIT    = 10;
  localparam int          CLK_CTL_WIDTH      = 14;
  // sync_timing_reg field: cas latency in the low bits
  localparam int          CAS_LAT_WIDTH      = 3;
  // memory clock enable divider (core clocks per memory clock)
  localparam logic [2:0]  MEM_CLK_DIV        = 3'h4;
  // remap window
  localparam logic [31:0] REMAP_WIN_OFFSET   = 32'h0040_0000;
  localparam logic [31:0] REMAP_WIN_SIZE     = 32'h0002_0000;
  localparam logic [31:0] REMAP_PHYS_BASE    = 32'h000A_0000;
  // memory command codes and mode word layout
  localparam logic [2:0]  CMD_NOP            = 3'h0;
  localparam logic [2:0]  CMD_REFRESH        = 3'h1;
  localparam logic [2:0]  CMD_MODE_SET       = 3'h2;
  localparam int          MODE_CAS_LSB       = 4;
  localparam int          MEM_ADDR_WIDTH     = 12;
  // requester grant bit positions
  localparam int          GNT_CPU            = 0;
  localparam int          GNT_GFX            = 1;
  localparam int          GNT_DISP_LO        = 2;
  localparam int          GNT_DISP_HI        = 3;

  typedef enum logic [3:0] {
    SEQ_IDLE  = 4'b0001,
    SEQ_SETUP = 4'b0010,
    SEQ_CMD   = 4'b0100,
    SEQ_GAP   = 4'b1000
  } sdc_seq_state_t;
endpackage : sdc_pkg

// ---- hdl/sdc_seq_if.sv ----
`timescale 1ns/10ps
interface sdc_seq_if;
  import sdc_pkg::*;
  logic                      memClkEn;
  logic                      refreshReq;
  logic                      modeSetReq;
  logic [1:0]                stagger;
  logic                      twoCycle;
  logic [CAS_LAT_WIDTH-1:0]  casLat;
  logic                      memCsN;
  logic [2:0]                memCmd;
  logic [1:0]                memBank;
  logic [MEM_ADDR_WIDTH-1:0] memAddr;
  logic                      busy;

  modport ctrl (output memClkEn, refreshReq, modeSetReq, stagger, twoCycle, casLat,
                input  memCsN, memCmd, memBank, memAddr, busy);
  modport seq  (input  memClkEn, refreshReq, modeSetReq, stagger, twoCycle, casLat,
                output memCsN, memCmd, memBank, memAddr, busy);
endinterface : sdc_seq_if

// ---- tb/sdc_sdram_model.sv ----
`timescale 1ns/10ps
module sdc_sdram_model
  import sdc_pkg::*;
(
  // clock
  input wire logic                      ref_clk,
  // memory command pins
  input wire logic                      memCsN,
  input wire logic [2:0]                memCmd,
  input wire logic [1:0]                memBank,
  input wire logic [MEM_ADDR_WIDTH-1:0] memAddr
);
  // command log, one entry for each command start
  int                        nCmd;
  int                        cyc;
  int                        lowCnt;
  int                        startLog [256];
  logic [2:0]                cmdLog   [256];
  logic [1:0]                bankLog  [256];
  logic [MEM_ADDR_WIDTH-1:0] addrLog  [256];
  logic [MEM_ADDR_WIDTH-1:0] preLog   [256];
  logic [MEM_ADDR_WIDTH-1:0] prevAddr;
  initial begin
    nCmd     = 0;
    cyc      = 0;
    lowCnt   = 0;
    prevAddr = '0;
  end
  // a command holds select low for one memory clock, so back-to-back commands are split by count
  always @(posedge ref_clk) begin
    cyc++;
    if (memCsN === 1'b0) begin
      if (lowCnt == 0 && nCmd < 256) begin
        cmdLog[nCmd]   = memCmd;
        bankLog[nCmd]  = memBank;
        addrLog[nCmd]  = memAddr;
        preLog[nCmd]   = prevAddr;
        startLog[nCmd] = cyc;
        nCmd++;
      end
      lowCnt = (lowCnt + 1) % MEM_CLK_DIV;
    end else begin
      lowCnt = 0;
    end
    prevAddr = memAddr;
  end
endmodule : sdc_sdram_model

// ---- tb/sdram_ctrl_config_bits_tb.sv ----
`timescale 1ns/10ps
module sdram_ctrl_config_bits_tb;
  import sdc_pkg::*;
  // design signals
  logic                      ref_clk, resetn, busWr, busRd, refreshTick;
  logic                      cpuReq, gfxReq, dispLoReq, dispHiReq, remapHit, memCsN, fbClkOe;
  logic [15:0]               busAddr;
  logic [31:0]               busWrData, busRdData, configBase, reqAddr, remapAddr;
  logic [3:0]                grant, memClkOe, r, prev;
  logic [2:0]                memCmd, cas;
  logic [1:0]                memBank;
  logic [MEM_ADDR_WIDTH-1:0] memAddr;
  // bench state
  int                        nErrors, compares, i, g, b, m, base, rrLast;
  integer                    seed;
  logic [31:0]               d, v, off;
  bit                        h;
  int                        gapTab [4] = '{0, 1, 2, 4};
  logic [31:0]               offTab [4] = '{32'h003F_FFFF, 32'h0040_0000, 32'h0041_FFFF, 32'h0042_0000};
  localparam logic [31:0]    CTL_BASE = 32'h248C_0000;

  sdc_ctrl_top DUT (.ref_clk, .resetn, .busAddr, .busWrData, .busWr, .busRd, .busRdData, .refreshTick,
    .cpuReq, .gfxReq, .dispLoReq, .dispHiReq, .grant, .configBase, .reqAddr, .remapHit, .remapAddr,
    .memCsN, .memCmd, .memBank, .memAddr, .memClkOe, .fbClkOe);
  sdc_sdram_model PM (.ref_clk, .memCsN, .memCmd, .memBank, .memAddr);

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    compares++;
    if (got !== exp) begin
      nErrors++;
      $display("mismatch t=%0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk
  // single-cycle strobes; a gap cycle follows so no strobe is assigned twice in one step
  task automatic wr(input logic [15:0] a, input logic [31:0] dat);
    @(posedge ref_clk);
    busWr     <= 1'b1;
    busAddr   <= a;
    busWrData <= dat;
    @(posedge ref_clk);
    busWr <= 1'b0;
  endtask : wr
  task automatic rdchk(input logic [15:0] a, input logic [31:0] exp, input string msg);
    @(posedge ref_clk);
    busRd   <= 1'b1;
    busAddr <= a;
    @(posedge ref_clk);
    busRd <= 1'b0;
    #1 chk(busRdData, exp, msg);
  endtask : rdchk
  task automatic waitCmds(input int n);
    int k;
    for (k = 0; k < 600 && PM.nCmd < n; k++) @(posedge ref_clk);
    repeat (40) @(posedge ref_clk);
  endtask : waitCmds
  // reference arbiter: urgent display first, then fixed order or rotation after the last grant
  function automatic logic [3:0] expGrant(input logic [3:0] q, input bit rr);
    int k;
    int c;
    expGrant = 4'h0;
    if (q[3]) return 4'h8;
    for (k = 1; k <= 3; k++) begin
      c = rr ? (rrLast + k) % 3 : k - 1;
      if (q[c] && expGrant == 4'h0) expGrant = 4'(1 << c);
    end
    if (expGrant != 4'h0) rrLast = $clog2(expGrant);
  endfunction : expGrant
  task automatic end_of_test;
    $display("compares %0d mismatches %0d", compares, nErrors);
    if (nErrors == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_of_test

  // clock
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  // watchdog, several times the expected run length
  initial begin
    repeat (30000) @(posedge ref_clk);
    nErrors++;
    $display("watchdog expired");
    end_of_test();
  end
  // main sequence
  initial begin
    {resetn, busWr, busRd, refreshTick, cpuReq, gfxReq, dispLoReq, dispHiReq} = '0;
    busAddr = '0;
    busWrData = '0;
    reqAddr = '0;
    nErrors = 0;
    compares = 0;
    rrLast = 2;
    seed = 32'h6ED6;
    configBase = $random(seed) & 32'hFF00_0000;
    repeat (3) @(posedge ref_clk);
    resetn <= 1'b1;
    rdchk(MEM_CTL_LOW_ADDR, 32'h248C_0040, "ctl low reset");
    rdchk(CLK_OUT_CTL_ADDR, 32'h0000_0801, "clk ctl reset");
    rdchk(16'h8408, 32'h0, "unmapped read");
    chk({fbClkOe, memClkOe}, 5'h1F, "clock pins after reset");
    for (i = 0; i < 6; i++) begin
      d = $random(seed) & 32'h0000_3FFF;
      wr(CLK_OUT_CTL_ADDR, d);
      rdchk(CLK_OUT_CTL_ADDR, d, "clk ctl rw");
      chk(memClkOe, 4'(~d[9:6]), "clock pins");
      chk(fbClkOe, 1'(~d[10]), "feedback pin");
    end
    $display("register test done");
    // every stagger code, 00 being the single bank setting
    for (g = 0; g < 4; g++) begin
      base = PM.nCmd;
      wr(MEM_CTL_LOW_ADDR, CTL_BASE | (32'(g) << 6));
      @(posedge ref_clk);
      refreshTick <= 1'b1;
      @(posedge ref_clk);
      refreshTick <= 1'b0;
      waitCmds(base + 4);
      chk(PM.nCmd - base, 4, "refresh count");
      for (b = 0; b < 4; b++) begin
        chk(PM.cmdLog[base+b], CMD_REFRESH, "refresh cmd");
        chk(PM.bankLog[base+b], b, "refresh bank");
        if (b > 0) chk(PM.startLog[base+b] - PM.startLog[base+b-1], 4 * (1 + gapTab[g]), "stagger");
      end
    end
    $display("stagger test done");
    base = PM.nCmd;
    wr(MEM_CTL_LOW_ADDR, CTL_BASE | 32'h10);
    waitCmds(base + 4);
    wr(MEM_CTL_LOW_ADDR, CTL_BASE | 32'h10);
    waitCmds(base + 8);
    chk(PM.nCmd - base, 4, "test refresh");
    wr(MEM_CTL_LOW_ADDR, CTL_BASE);
    $display("test refresh done");
    // a repeated write of one must not start a second mode set
    for (i = 0; i < 4; i++) begin
      cas = 3'($random(seed));
      d = CTL_BASE | (32'(i % 2) << 5);
      base = PM.nCmd;
      wr(SYNC_TIMING_ADDR, {29'h0, cas});
      wr(MEM_CTL_LOW_ADDR, d);
      wr(MEM_CTL_LOW_ADDR, d | 32'h1);
      wr(MEM_CTL_LOW_ADDR, d | 32'h1);
      waitCmds(base + 2);
      chk(PM.nCmd - base, 1, "mode set count");
      chk(PM.cmdLog[base], CMD_MODE_SET, "mode set cmd");
      chk(PM.addrLog[base], {cas, 4'h0}, "mode latency");
      if (i % 2 == 1) chk(PM.preLog[base], {cas, 4'h0}, "address setup");
    end
    $display("mode set test done");
    // round robin first, while the rotation still points at low display
    for (m = 1; m >= 0; m--) begin
      wr(MEM_CTL_LOW_ADDR, CTL_BASE | (32'(m) << 3));
      prev = 4'h0;
      repeat (200) begin
        @(posedge ref_clk);
        v = $random(seed);
        r = {v[3] & v[4] & v[5], v[2:0]};
        {dispHiReq, dispLoReq, gfxReq, cpuReq} <= r;
        #1 chk(grant, expGrant(prev, m[0]), "grant");
        prev = r;
      end
      @(posedge ref_clk);
      {dispHiReq, dispLoReq, gfxReq, cpuReq} <= 4'h0;
    end
    $display("arbiter test done");
    for (m = 0; m < 2; m++) begin
      wr(MEM_CTL_LOW_ADDR, CTL_BASE | (32'(m) << 2));
      for (i = 0; i < 12; i++) begin
        off = (i < 4) ? offTab[i] : 32'h0040_0000 + ($random(seed) & 32'h0003_FFFF);
        h = m == 1 && off >= 32'h0040_0000 && off < 32'h0042_0000;
        @(posedge ref_clk);
        reqAddr <= configBase + off;
        @(posedge ref_clk);
        #1 chk(remapHit, h, "remap hit");
        if (h) chk(remapAddr, 32'h000A_0000 + off - 32'h0040_0000, "remap addr");
      end
    end
    $display("remap test done");
    end_of_test();
  end
endmodule : sdram_ctrl_config_bits_tb
